// >>> ilpf_isa_slave.sv
// Behavioural ISA slave facing the legacy pin block: answers each bus cycle.
// Assumes the clk_in domain; the bench sets how many cycles ready is held low.
`timescale 1ns/1ps
module ilpf_isa_slave (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Cycle seen from the block
    input wire logic cycle_busy_in,
    input wire logic [31:0] wait_len_in,
    // Ready line, pulled up when released
    output logic channel_ready_out
);
    logic busy_q;
    int cnt_q;
    // Hold ready low for wait_len cycles after a cycle starts
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
        end else begin
            busy_q <= cycle_busy_in;
            if (cycle_busy_in && !busy_q) begin
                cnt_q <= int'(wait_len_in);
            end else if (cnt_q > 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
    // Pull-up gives high whenever the slave lets go
    assign channel_ready_out = (cnt_q == 0);
endmodule : ilpf_isa_slave

// >>> ilpf_pkg.sv
// Shared constants and pin synchroniser for the legacy ISA-side pin functions.
// Assumes one 40 MHz clock standing in for the PCI clock and an active-low asynchronous reset.
`timescale 1ns/1ps
package ilpf_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 40;
    localparam int BCLK_DIV = 4;
    localparam int INIT_PULSE_NS = 400;
    localparam int INIT_CYCLES = (INIT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_CYCLE_BCLKS = 4;
    // Interrupt 12 pin function select
    localparam logic [1:0] IRQ12_SEL_MERGE = 2'h0;
    localparam logic [1:0] IRQ12_SEL_SMBALERT = 2'h1;
    localparam logic [1:0] IRQ12_SEL_USBOC = 2'h2;
    localparam logic [1:0] IRQ12_SEL_MOUSE = 2'h3;
    // Interrupt controller line numbers
    localparam int IRQ_KBD = 1;
    localparam int IRQ_MOUSE = 12;
    localparam int IRQ_IDE_PRI = 14;
    localparam int IRQ_IDE_SEC = 15;
    localparam logic [15:0] IRQ_SHARED_MASK = 16'h0ef8;
    // Positions of the single pins in the synchronised vector
    localparam int SP_KBD = 0;
    localparam int SP_MOUSE = 1;
    localparam int SP_CHK_N = 2;
    localparam int SP_RDY = 3;
    localparam int SP_BIOS = 4;
    localparam int SP_A20G = 5;
    localparam int SP_KEYBOARD_RESET_CMD_N_N = 6;
    localparam int SP_PCI_INTERRUPT_A_N_N = 7;
    localparam int SYNC_W = 24;
    localparam logic [SYNC_W-1:0] SYNC_RST = 24'h0000c4;
endpackage : ilpf_pkg

////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser; the first stage feeds only the second.
module ilpf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Stage registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : ilpf_sync

// >>> ilpf_top.sv
// Legacy ISA-side pin functions: bus clock, keyboard interrupts, channel check and ready,
// multiplexed interrupt pins, BIOS bus select, gate A20 and keyboard reset.
// Assumes pins are asynchronous and configuration ports come from the clk_in domain.
// Contract
// - ISA bus clock is the PCI clock divided by four, about 8 MHz; the code gives 10 MHz from its 40 MHz clock.
// - Keyboard interrupt input drives interrupt controller line 1.
// - Mouse interrupt merges with the IRQ12 pin per two-bit select.
// - Low channel check input sets the system control port status bit.
// - Slave holding channel ready low extends the cycle until it rises.
// - Select turns eight IRQ pins into low bus master requests setting status.
// - IRQ12 select for SMBus alert, when enabled, raises SMI or SCI.
// - IRQ12 select for over-current, when enabled, feeds USB second source.
// - Primary native bit makes IRQ14 high shared IRQ combined with PCI line A.
// - Secondary native bit makes IRQ15 high shared IRQ combined with line A.
// - BIOS accesses go to ISA when select is 1, LPC when 0.
// - Current BIOS select level is readable by software.
// - Keyboard gate A20 input influences the A20 mask output.
// - A20 mask output is OR of keyboard gate and port A20 enable.
// - Low keyboard reset command generates an init interrupt to the processor.
`timescale 1ns/1ps
module ilpf_top
    import ilpf_pkg::*;
#(
    parameter int MIN_BCLKS = MIN_CYCLE_BCLKS,
    parameter int INIT_LEN = INIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Pins from keyboard controller, ISA slaves and PCI
    input wire logic ext_keyboard_irq_in,
    input wire logic ext_mouse_irq_in,
    input wire logic channel_check_n_in,
    input wire logic channel_ready_in,
    input wire logic [15:0] irq_pins_in,
    input wire logic pci_interrupt_a_n_in,
    input wire logic bios_bus_select_in,
    input wire logic keyboard_gate_a20_in,
    input wire logic keyboard_reset_cmd_n_in,
    // Configuration
    input wire logic pm_pin_function_select_in,
    input wire logic [1:0] irq12_mux_config_in,
    input wire logic smbus_alert_enable_in,
    input wire logic usb_overcurrent_enable_in,
    input wire logic ide_primary_native_in,
    input wire logic ide_secondary_native_in,
    input wire logic a20_enable_bit_in,
    input wire logic channel_check_clear_in,
    input wire logic bus_master_status_clear_in,
    // ISA cycle control
    input wire logic cycle_start_in,
    output logic cycle_busy_out,
    output logic cycle_done_out,
    // Clock and interrupt outputs
    output logic bclk_out,
    output logic [15:0] pic_irq_out,
    output logic shared_pci_interrupt_a_n_out,
    output logic smbus_alert_out,
    output logic usb_overcurrent_second_n_out,
    // Status
    output logic channel_check_status_out,
    output logic bus_master_request_out,
    output logic bus_master_status_out,
    output logic bios_to_isa_out,
    output logic bios_select_level_out,
    // Processor open-drain pins
    output logic address_bit20_mask_n_out,
    output logic address_bit20_mask_n_oe_out,
    output logic init_n_out,
    output logic init_n_oe_out
);
    typedef enum logic [1:0] {CYC_IDLE, CYC_CMD, CYC_DONE} ilpf_cyc_t;

    logic [SYNC_W-1:0] s;
    logic [1:0] div_q, div_d;
    logic bclk_q, bclk_d, bclk_en;
    ilpf_cyc_t cyc_q, cyc_d;
    logic [7:0] wait_q, wait_d;
    logic [15:0] pic_q, pic_d;
    logic pci_interrupt_a_n_q, pci_interrupt_a_n_d, smb_q, smb_d, usboc_q, usboc_d;
    logic chk_q, chk_d, bmr_q, bmr_d, bms_q, bms_d, bios_q, bios_d, a20_q, a20_d;
    logic keyboard_reset_cmd_n_prev_q, keyboard_reset_cmd_n_prev_d;
    logic [7:0] init_q, init_d;

    // Bus master requests live on IRQ 11:9 and 7:3
    function automatic logic [7:0] ilpf_bm_reqs(input logic [15:0] pins);
        ilpf_bm_reqs = ~{pins[11:9], pins[7:3]};
    endfunction : ilpf_bm_reqs

    // Pin synchroniser
    ilpf_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({irq_pins_in, pci_interrupt_a_n_in, keyboard_reset_cmd_n_in, keyboard_gate_a20_in,
                   bios_bus_select_in, channel_ready_in, channel_check_n_in, ext_mouse_irq_in,
                   ext_keyboard_irq_in}),
        .sync_out(s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock divider and ISA cycle sequencer
    always_comb begin
        div_d = div_q + 2'h1;
        bclk_d = div_q[1];
        bclk_en = (div_q == 2'(BCLK_DIV - 1));
        cyc_d = cyc_q;
        wait_d = wait_q;
        unique case (cyc_q)
            CYC_IDLE: begin
                wait_d = 8'h00;
                if (cycle_start_in) begin
                    cyc_d = CYC_CMD;
                end
            end
            CYC_CMD: begin
                if (bclk_en) begin
                    if (wait_q < 8'(MIN_BCLKS - 1)) begin
                        wait_d = wait_q + 8'h01;
                    end else if (s[SP_RDY]) begin
                        cyc_d = CYC_DONE;
                    end
                end
            end
            CYC_DONE: begin
                cyc_d = CYC_IDLE;
            end
            default: begin
                cyc_d = CYC_IDLE;
            end
        endcase
    end

    // Divider and sequencer registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q <= 2'h0;
            bclk_q <= 1'b0;
            cyc_q <= CYC_IDLE;
            wait_q <= 8'h00;
        end else begin
            div_q <= div_d;
            bclk_q <= bclk_d;
            cyc_q <= cyc_d;
            wait_q <= wait_d;
        end
    end

    assign bclk_out = bclk_q;
    assign cycle_busy_out = (cyc_q == CYC_CMD);
    assign cycle_done_out = (cyc_q == CYC_DONE);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt routing, pin functions, flags and init pulse
    always_comb begin
        pic_d = s[SYNC_W-1:8] & IRQ_SHARED_MASK & {16{~pm_pin_function_select_in}};
        pic_d[IRQ_KBD] = s[SP_KBD];
        unique case (irq12_mux_config_in)
            IRQ12_SEL_MERGE: pic_d[IRQ_MOUSE] = s[SP_MOUSE] | s[8 + IRQ_MOUSE];
            default: pic_d[IRQ_MOUSE] = s[SP_MOUSE];
        endcase
        pic_d[IRQ_IDE_PRI] = s[8 + IRQ_IDE_PRI] & ~ide_primary_native_in;
        pic_d[IRQ_IDE_SEC] = s[8 + IRQ_IDE_SEC] & ~ide_secondary_native_in;
        pci_interrupt_a_n_d = ~(~s[SP_PCI_INTERRUPT_A_N_N] | (ide_primary_native_in & s[8 + IRQ_IDE_PRI])
                   | (ide_secondary_native_in & s[8 + IRQ_IDE_SEC]));
        smb_d = (irq12_mux_config_in == IRQ12_SEL_SMBALERT) & smbus_alert_enable_in
                & ~s[8 + IRQ_MOUSE];
        usboc_d = ~((irq12_mux_config_in == IRQ12_SEL_USBOC) & usb_overcurrent_enable_in
                  & ~s[8 + IRQ_MOUSE]);
        chk_d = ~s[SP_CHK_N] | (chk_q & ~channel_check_clear_in);
        bmr_d = pm_pin_function_select_in & (|ilpf_bm_reqs(s[SYNC_W-1:8]));
        bms_d = bmr_d | (bms_q & ~bus_master_status_clear_in);
        bios_d = s[SP_BIOS];
        a20_d = s[SP_A20G] | a20_enable_bit_in;
        keyboard_reset_cmd_n_prev_d = s[SP_KEYBOARD_RESET_CMD_N_N];
        init_d = (init_q != 8'h00) ? init_q - 8'h01 : 8'h00;
        if (keyboard_reset_cmd_n_prev_q && !s[SP_KEYBOARD_RESET_CMD_N_N]) begin
            init_d = 8'(INIT_LEN);
        end
    end

    // Routing and flag registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pic_q <= 16'h0000;
            pci_interrupt_a_n_q <= 1'b1;
            smb_q <= 1'b0;
            usboc_q <= 1'b1;
            chk_q <= 1'b0;
            bmr_q <= 1'b0;
            bms_q <= 1'b0;
            bios_q <= 1'b0;
            a20_q <= 1'b0;
            keyboard_reset_cmd_n_prev_q <= 1'b1;
            init_q <= 8'h00;
        end else begin
            pic_q <= pic_d;
            pci_interrupt_a_n_q <= pci_interrupt_a_n_d;
            smb_q <= smb_d;
            usboc_q <= usboc_d;
            chk_q <= chk_d;
            bmr_q <= bmr_d;
            bms_q <= bms_d;
            bios_q <= bios_d;
            a20_q <= a20_d;
            keyboard_reset_cmd_n_prev_q <= keyboard_reset_cmd_n_prev_d;
            init_q <= init_d;
        end
    end

    // Output drive; open-drain pins drive low only
    assign pic_irq_out = pic_q;
    assign shared_pci_interrupt_a_n_out = pci_interrupt_a_n_q;
    assign smbus_alert_out = smb_q;
    assign usb_overcurrent_second_n_out = usboc_q;
    assign channel_check_status_out = chk_q;
    assign bus_master_request_out = bmr_q;
    assign bus_master_status_out = bms_q;
    assign bios_to_isa_out = bios_q;
    assign bios_select_level_out = bios_q;
    assign address_bit20_mask_n_out = 1'b0;
    assign address_bit20_mask_n_oe_out = ~a20_q;
    assign init_n_out = 1'b0;
    assign init_n_oe_out = (init_q != 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence bclk_low3;
        !$rose(bclk_out) [*3];
    endsequence

    a_bclk_period: assert property ($rose(bclk_out) |=> bclk_low3 ##1 $rose(bclk_out))
        else $error("bus clock period is not four cycles");
    a_kbd_route: assert property (s[SP_KBD] |=> pic_irq_out[IRQ_KBD])
        else $error("keyboard interrupt not on line 1");
    a_mouse_merge: assert property ((irq12_mux_config_in == IRQ12_SEL_MERGE && s[8 + IRQ_MOUSE])
        |=> pic_irq_out[IRQ_MOUSE])
        else $error("irq12 pin not merged");
    a_chk_status: assert property (!s[SP_CHK_N] |=> channel_check_status_out)
        else $error("channel check status not set");
    a_chk_hold: assert property ((channel_check_status_out && !channel_check_clear_in)
        |=> channel_check_status_out)
        else $error("channel check status lost");
    a_chk_clear: assert property ((s[SP_CHK_N] && channel_check_clear_in) |=> !channel_check_status_out)
        else $error("channel check status not cleared");
    a_ready_extend: assert property ((cycle_busy_out && !s[SP_RDY]) |=> !cycle_done_out)
        else $error("cycle ended while not ready");
    a_cycle_ends: assert property ((cycle_busy_out && wait_q == 8'(MIN_BCLKS - 1) && s[SP_RDY] && bclk_en)
        |=> cycle_done_out ##1 !cycle_busy_out)
        else $error("ready cycle did not end");
    a_bm_status: assert property (bus_master_request_out |-> bus_master_status_out)
        else $error("bus master status not set");
    a_smb_alert: assert property ((irq12_mux_config_in == IRQ12_SEL_SMBALERT && smbus_alert_enable_in
        && !s[8 + IRQ_MOUSE]) |=> smbus_alert_out)
        else $error("smbus alert not raised");
    a_usb_oc: assert property ((irq12_mux_config_in == IRQ12_SEL_USBOC && usb_overcurrent_enable_in
        && !s[8 + IRQ_MOUSE]) |=> !usb_overcurrent_second_n_out)
        else $error("over-current not routed");
    a_ide_primary: assert property ((ide_primary_native_in && s[8 + IRQ_IDE_PRI])
        |=> !shared_pci_interrupt_a_n_out && !pic_irq_out[IRQ_IDE_PRI])
        else $error("primary native irq not shared");
    a_ide_second: assert property ((ide_secondary_native_in && s[8 + IRQ_IDE_SEC])
        |=> !shared_pci_interrupt_a_n_out && !pic_irq_out[IRQ_IDE_SEC])
        else $error("secondary native irq not shared");
    a_bios_route: assert property (##1 bios_to_isa_out == $past(s[SP_BIOS]))
        else $error("bios route wrong");
    a_bios_level: assert property (bios_select_level_out == bios_to_isa_out)
        else $error("bios level not readable");
    a_a20_gate: assert property ((s[SP_A20G] || a20_enable_bit_in) |=> !address_bit20_mask_n_oe_out)
        else $error("a20 gate ignored");
    a_a20_mask: assert property ((!s[SP_A20G] && !a20_enable_bit_in) |=> address_bit20_mask_n_oe_out)
        else $error("a20 mask not driven");
    a_init_pulse: assert property ((keyboard_reset_cmd_n_prev_q && !s[SP_KEYBOARD_RESET_CMD_N_N]) |=> init_n_oe_out [*8])
        else $error("init pulse missing");
    a_unsel_quiet: assert property (!pm_pin_function_select_in |=> !bus_master_request_out)
        else $error("bus master request active while unselected");
    a_unsel_smb: assert property ((irq12_mux_config_in != IRQ12_SEL_SMBALERT || !smbus_alert_enable_in)
        |=> !smbus_alert_out)
        else $error("smbus alert active while unselected");
    a_unsel_usb: assert property ((irq12_mux_config_in != IRQ12_SEL_USBOC || !usb_overcurrent_enable_in)
        |=> usb_overcurrent_second_n_out)
        else $error("over-current active while unselected");
    a_unsel_irq: assert property (pm_pin_function_select_in |=> (pic_irq_out & IRQ_SHARED_MASK) == 16'h0000)
        else $error("irq pins active while requests selected");
endmodule : ilpf_top

// >>> tb_top.sv
// Self-checking bench for the legacy ISA-side pin functions.
// Assumes ilpf_pkg and ilpf_top; pins driven at the falling edge.
`timescale 1ns/1ps
module tb_top;
    import ilpf_pkg::*;
    localparam int MINB = 4;
    localparam int ILEN = 16;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic kbd = 0, mouse = 0, chk_n = 1, rdy, bios = 0, a20g = 0, keyboard_reset_cmd_n_n = 1, inta_n = 1;
    logic pm = 0, smb_en = 1, oc_en = 1, pri = 0, sec = 0, a20_enable_bit = 0, chk_clr = 0, bm_clr = 0, start = 0;
    logic [1:0] sel = 2'h0;
    logic [15:0] pins = 16'h0000;
    logic busy, done, bclk, inta_out, smb, oc_n, chk_st, bm_req, bm_st, b_isa, b_lvl, a20, a20_oe, init, init_oe;
    logic [15:0] pic;
    logic [7:0] bq;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int wait_len = 0;
    int len;
    // Clock
    always #12.5 clk_in = ~clk_in;
    ilpf_top #(.MIN_BCLKS(MINB), .INIT_LEN(ILEN)) i_ilpf_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .ext_keyboard_irq_in(kbd), .ext_mouse_irq_in(mouse), .channel_check_n_in(chk_n),
        .channel_ready_in(rdy), .irq_pins_in(pins), .pci_interrupt_a_n_in(inta_n),
        .bios_bus_select_in(bios), .keyboard_gate_a20_in(a20g), .keyboard_reset_cmd_n_in(keyboard_reset_cmd_n_n),
        .pm_pin_function_select_in(pm), .irq12_mux_config_in(sel), .smbus_alert_enable_in(smb_en),
        .usb_overcurrent_enable_in(oc_en), .ide_primary_native_in(pri), .ide_secondary_native_in(sec),
        .a20_enable_bit_in(a20_enable_bit), .channel_check_clear_in(chk_clr), .bus_master_status_clear_in(bm_clr),
        .cycle_start_in(start), .cycle_busy_out(busy), .cycle_done_out(done), .bclk_out(bclk),
        .pic_irq_out(pic), .shared_pci_interrupt_a_n_out(inta_out), .smbus_alert_out(smb),
        .usb_overcurrent_second_n_out(oc_n), .channel_check_status_out(chk_st),
        .bus_master_request_out(bm_req), .bus_master_status_out(bm_st), .bios_to_isa_out(b_isa),
        .bios_select_level_out(b_lvl), .address_bit20_mask_n_out(a20), .address_bit20_mask_n_oe_out(a20_oe),
        .init_n_out(init), .init_n_oe_out(init_oe));
    ilpf_isa_slave i_ilpf_isa_slave (.clk_in(clk_in), .reset_n_in(reset_n_in), .cycle_busy_in(busy),
        .wait_len_in(wait_len), .channel_ready_out(rdy));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic settle();
        repeat (4) @(negedge clk_in);
    endtask : settle
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // One ISA cycle; len counts cycles with busy high
    task automatic run_cycle(input int w, output int n);
        wait_len = w;
        n = 0;
        @(negedge clk_in);
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        while (done !== 1'b1 && n < 500) begin
            n++;
            @(negedge clk_in);
        end
        check("done_high", 16'h1, 16'(done));
        check("busy_at_done", 16'h0, 16'(busy));
        @(negedge clk_in);
        check("done_pulse", 16'h0, 16'(done));
    endtask : run_cycle
    // Cycle ceiling
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(negedge clk_in);
        check("pic_rst", 16'h0, pic);
        check("inta_rst", 16'h1, 16'(inta_out));
        check("bclk_rst", 16'h0, 16'(bclk));
        check("oe_rst", 16'h2, {14'h0, a20_oe, init_oe});
        reset_n_in = 1'b1;
        settle();
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_in);
            bq[i] = bclk;
        end
        for (int i = 0; i < 6; i++) check("bclk", 16'(!bq[i]), 16'(bq[i+2]));
        kbd = 1'b1;
        settle();
        check("irq1", 16'h0002, pic);
        kbd = 1'b0;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                sel = s[1:0];
                pins[12] = p[0];
                mouse = ~p[0];
                settle();
                check("irq12", {3'h0, (s == 0) || (p == 0), 12'h0}, pic);
                check("smbus", 16'(s == 1 && p == 0), 16'(smb));
                check("usb_oc_n", 16'(!(s == 2 && p == 0)), 16'(oc_n));
            end
        end
        smb_en = 1'b0;
        oc_en = 1'b0;
        pins[12] = 1'b0;
        for (int s = 1; s < 3; s++) begin
            sel = s[1:0];
            settle();
            check("smb_off", 16'h0, 16'(smb));
            check("usb_oc_off", 16'h1, 16'(oc_n));
        end
        smb_en = 1'b1;
        oc_en = 1'b1;
        sel = 2'h0;
        pins = 16'h0;
        mouse = 1'b0;
        chk_n = 1'b0;
        settle();
        check("chk_set", 16'h1, 16'(chk_st));
        chk_n = 1'b1;
        settle();
        check("chk_hold", 16'h1, 16'(chk_st));
        chk_clr = 1'b1;
        @(negedge clk_in);
        chk_clr = 1'b0;
        settle();
        check("chk_clr", 16'h0, 16'(chk_st));
        chk_n = 1'b0;
        chk_clr = 1'b1;
        settle();
        check("chk_set_wins", 16'h1, 16'(chk_st));
        chk_n = 1'b1;
        settle();
        chk_clr = 1'b0;
        check("chk_clr_held", 16'h0, 16'(chk_st));
        pins = 16'h0ef8;
        settle();
        pm = 1'b1;
        settle();
        check("bm_idle", 16'h0, {pic[15:2], bm_req, bm_st});
        pins[5] = 1'b0;
        settle();
        check("bm_req", 16'h3, {14'h0, bm_req, bm_st});
        pins = 16'h0ef8;
        bm_clr = 1'b1;
        settle();
        bm_clr = 1'b0;
        settle();
        check("bm_clr", 16'h0, {14'h0, bm_req, bm_st});
        pm = 1'b0;
        pins = 16'h0020;
        settle();
        check("irq5", 16'h0020, {pic[15:1], bm_req});
        for (int k = 0; k < 4; k++) begin
            pins = k[0] ? 16'h8000 : 16'h4000;
            pri = k[1] & ~k[0];
            sec = k[1] & k[0];
            settle();
            check("ide_pic", k[1] ? 16'h0 : pins, pic);
            check("ide_inta", 16'(!k[1]), 16'(inta_out));
        end
        pins = 16'h0;
        inta_n = 1'b0;
        settle();
        check("inta_pass", 16'h0, 16'(inta_out));
        inta_n = 1'b1;
        settle();
        check("inta_idle", 16'h1, 16'(inta_out));
        for (int v = 1; v >= 0; v--) begin
            bios = v[0];
            settle();
            check("bios", {14'h0, v[0], v[0]}, {14'h0, b_isa, b_lvl});
        end
        for (int k = 0; k < 4; k++) begin
            a20g = k[0];
            a20_enable_bit = k[1];
            settle();
            check("a20", {14'h0, k == 0, 1'b0}, {14'h0, a20_oe, a20});
        end
        keyboard_reset_cmd_n_n = 1'b0;
        len = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_in);
            if (init_oe === 1'b1) len++;
        end
        check("init_len", 16'(ILEN), 16'(len));
        check("init_out", 16'h0, 16'(init));
        keyboard_reset_cmd_n_n = 1'b1;
        run_cycle(0, len);
        check("cyc_fast", 16'h1, 16'(len >= MINB * 4 - 4 && len <= MINB * 4 + 8));
        run_cycle(40, len);
        check("cyc_slow", 16'h1, 16'(len >= 42 && len <= 60));
        summarize();
    end
endmodule : tb_top
